/* File: hdl/mcr_misc_control.v */
/*
 Misc control register bank: two 8-bit control registers, interrupt status and
 mask, external interrupt sensitivity, clock prescaler, clock out, beep, top-level
 interrupt and slave-select steering, on an AHB-Lite slave.
 Assumes pins arrive asynchronously and cpu level / halt inputs are synchronous.
*/
// The AHB-Lite slave port was decided locally.
`include "mcr_map.vh"
`default_nettype none
//Contract
//- Both control registers reset to zero
//- High field sets lines two, three sensitivity
//- Low field sets lines zero, one sensitivity
//- Port A polarity inverts line zero
//- Port B polarity inverts line two
//- Sensitivity writes only at interrupt level three
//- Clock out drives osc/2 on pin zero
//- Clock out suspended during active halt
//- Slow mode prescaler divides 4/8/16/32
//- Normal mode cpu clock is osc/2
//- Beep field gives 2k/1k/500 Hz
//- Beep keeps running in active halt
//- Top edge writable only while disabled
//- Top enable gates top pin detection
//- Clearing top enable may raise spurious interrupt
//- Slave select from pin or internal bit
//- Event needs pin configured and unmasked
module mcr_misc_control (
   input wire clock,
   input wire reset_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   input wire irq_level_bit_high,
   input wire irq_level_bit_low,
   input wire cpu_irq_mask,
   input wire active_halt,
   input wire [3:0] ext_irq_pins,
   input wire [3:0] ext_irq_config_ok,
   input wire top_level_irq_pin,
   input wire spi_ss_pin,
   output reg [3:0] ext_irq_req,
   output reg top_irq_req,
   output reg cpu_clock_enable,
   output reg port_f_pin_zero,
   output reg port_f_pin_zero_alt,
   output reg port_f_pin_one,
   output reg port_f_pin_one_alt,
   output reg spi_ss_level,
   output reg port_c_pin_seven_free,
   output wire irq
);
   reg [7:0] misc_control_one;
   reg [7:0] misc_control_two;
   reg [5:0] irq_stat;
   reg [5:0] irq_mask;
   reg ph_write;
   reg ph_read;
   reg [7:0] ph_addr;
   reg [31:0] rdata;
   reg [3:0] sync_a;
   reg [3:0] sync_b;
   reg [3:0] sync_c;
   reg [3:0] pin_level;
   reg [2:0] top_sync;
   reg top_level;
   reg top_en_prev;
   reg [2:0] ss_sync;
   reg ss_level;
   reg [4:0] cpu_div;
   reg osc_half;
   reg [15:0] beep_cnt;
   reg [1:0] beep_oct;
   reg [3:0] ev;
   reg top_ev;
   reg [2:0] top_edge_sel;
   reg [3:0] pin_next;
   reg [3:0] ev_rise;
   reg [3:0] ev_fall;
   reg [5:0] next_stat;
   integer i;
   wire level3 = irq_level_bit_high & irq_level_bit_low;
   wire addr_take = hsel & hready & htrans[1];
   wire [1:0] sens_hi = misc_control_one[`MCR_SENS_HI_MSB:`MCR_SENS_HI_LSB];
   wire [1:0] sens_lo = misc_control_one[`MCR_SENS_LO_MSB:`MCR_SENS_LO_LSB];
   wire [1:0] presc = misc_control_one[`MCR_PRESC_MSB:`MCR_PRESC_LSB];
   wire [1:0] beep_sel = misc_control_two[`MCR_BEEP_MSB:`MCR_BEEP_LSB];
   wire top_en = misc_control_two[`MCR_TOP_EN_BIT];
   localparam [31:0] beep_half_word = `MCR_BEEP_HALF_2K;
   wire [15:0] beep_half = beep_half_word[15:0];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata;
   assign irq = |(irq_stat & irq_mask);

   // Bus address phase capture; data phase next cycle, zero wait states
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         ph_write <= 1'b0;
         ph_read <= 1'b0;
         ph_addr <= 8'h00;
      end
      else
      begin
         ph_write <= addr_take & hwrite;
         ph_read <= addr_take & ~hwrite;
         ph_addr <= haddr[7:0];
      end
   end

   always @(posedge clock)
   begin
      if (!reset_n)
         rdata <= 32'h00000000;
      else if (addr_take & ~hwrite)
      begin
         case (haddr[7:0])
            `MCR_OFF_CTRL_ONE: rdata <= {24'h000000, misc_control_one};
            `MCR_OFF_CTRL_TWO: rdata <= {24'h000000, misc_control_two};
            `MCR_OFF_IRQ_STAT: rdata <= {26'h0000000, irq_stat};
            `MCR_OFF_IRQ_MASK: rdata <= {26'h0000000, irq_mask};
            default: rdata <= 32'h00000000;
         endcase
      end
   end

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         misc_control_one <= `MCR_RESET_VAL;
         misc_control_two <= `MCR_RESET_VAL;
         irq_mask <= 6'h00;
      end
      else if (ph_write)
      begin
         case (ph_addr)
            `MCR_OFF_CTRL_ONE:
            begin
               misc_control_one[`MCR_CLK_OUT_BIT] <= hwdata[`MCR_CLK_OUT_BIT];
               misc_control_one[`MCR_PRESC_MSB:`MCR_SLOW_BIT] <= hwdata[2:0];
               if (level3)
               begin
                  misc_control_one[7:6] <= hwdata[7:6];
                  misc_control_one[4:3] <= hwdata[4:3];
               end
            end
            `MCR_OFF_CTRL_TWO:
            begin
               misc_control_two[7:4] <= hwdata[7:4];
               misc_control_two[2:0] <= hwdata[2:0];
               // Edge is judged against the enable held before this write
               if (!top_en)
                  misc_control_two[`MCR_TOP_EDGE_BIT] <= hwdata[`MCR_TOP_EDGE_BIT];
            end
            `MCR_OFF_IRQ_MASK: irq_mask <= hwdata[5:0];
            default: irq_mask <= irq_mask;
         endcase
      end
   end

   // Three-stage synchronisers; a change counts when stages two and three agree
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         sync_a <= 4'hf;
         sync_b <= 4'hf;
         sync_c <= 4'hf;
         pin_level <= 4'hf;
         top_sync <= 3'b000;
         top_level <= 1'b0;
         ss_sync <= 3'b111;
         ss_level <= 1'b1;
      end
      else
      begin
         // Raw slave-select pin is asynchronous too
         ss_sync <= {ss_sync[1:0], spi_ss_pin};
         if (ss_sync[1] == ss_sync[2])
            ss_level <= ss_sync[2];
         sync_a <= ext_irq_pins;
         sync_b <= sync_a;
         sync_c <= sync_b;
         pin_level <= pin_next;
         top_sync <= {top_sync[1:0], top_level_irq_pin};
         if (top_sync[1] == top_sync[2])
            top_level <= top_sync[2];
      end
   end

   // Line 0 and 1 use the low field, 2 and 3 the high field
   always @*
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         pin_next[i] = (sync_b[i] == sync_c[i]) ? sync_c[i] : pin_level[i];
         ev_rise[i] = pin_next[i] & ~pin_level[i];
         ev_fall[i] = ~pin_next[i] & pin_level[i];
      end
      ev[0] = 1'b0;
      ev[1] = 1'b0;
      ev[2] = 1'b0;
      ev[3] = 1'b0;
      case (sens_lo)
         2'b00: ev[1] = ev_fall[1] | ~pin_level[1];
         2'b01: ev[1] = ev_rise[1];
         2'b10: ev[1] = ev_fall[1];
         default: ev[1] = ev_rise[1] | ev_fall[1];
      endcase
      case (sens_hi)
         2'b00: ev[3] = ev_fall[3] | ~pin_level[3];
         2'b01: ev[3] = ev_rise[3];
         2'b10: ev[3] = ev_fall[3];
         default: ev[3] = ev_rise[3] | ev_fall[3];
      endcase
      if (misc_control_two[`MCR_POL_A_BIT])
      begin
         case (sens_lo)
            2'b00: ev[0] = ev_rise[0] | pin_level[0];
            2'b01: ev[0] = ev_fall[0];
            2'b10: ev[0] = ev_rise[0];
            default: ev[0] = ev_rise[0] | ev_fall[0];
         endcase
      end
      else
      begin
         case (sens_lo)
            2'b00: ev[0] = ev_fall[0] | ~pin_level[0];
            2'b01: ev[0] = ev_rise[0];
            2'b10: ev[0] = ev_fall[0];
            default: ev[0] = ev_rise[0] | ev_fall[0];
         endcase
      end
      if (misc_control_two[`MCR_POL_B_BIT])
      begin
         case (sens_hi)
            2'b00: ev[2] = ev_rise[2] | pin_level[2];
            2'b01: ev[2] = ev_fall[2];
            2'b10: ev[2] = ev_rise[2];
            default: ev[2] = ev_rise[2] | ev_fall[2];
         endcase
      end
      else
      begin
         case (sens_hi)
            2'b00: ev[2] = ev_fall[2] | ~pin_level[2];
            2'b01: ev[2] = ev_rise[2];
            2'b10: ev[2] = ev_fall[2];
            default: ev[2] = ev_rise[2] | ev_fall[2];
         endcase
      end
      ev = ev & ext_irq_config_ok;
      top_edge_sel = {top_sync[1] == top_sync[2], top_sync[2], top_level};
      // Edge on the debounced level; the level itself updates the same cycle
      top_ev = top_edge_sel[2] & (top_edge_sel[1] != top_edge_sel[0])
               & (top_edge_sel[1] == misc_control_two[`MCR_TOP_EDGE_BIT]);
      // Disable edge is reported, not hidden
      top_ev = (top_ev & top_en) | (top_en_prev & ~top_en);
      next_stat = irq_stat;
      if (ph_write && ph_addr == `MCR_OFF_IRQ_STAT)
         next_stat = irq_stat & ~hwdata[5:0];
      // Set wins over a same-cycle clear
      next_stat = next_stat | {top_ev, ev[3], ev[2], ev[1], ev[0], 1'b0};
   end

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         ext_irq_req <= 4'h0;
         top_irq_req <= 1'b0;
         top_en_prev <= 1'b0;
         irq_stat <= 6'h00;
      end
      else
      begin
         ext_irq_req <= cpu_irq_mask ? 4'h0 : ev;
         top_irq_req <= top_ev;
         top_en_prev <= top_en;
         irq_stat <= next_stat;
      end
   end

   // Clock generation: osc/2 toggle, prescaler, beep divider
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         cpu_div <= 5'h00;
         osc_half <= 1'b0;
         cpu_clock_enable <= 1'b0;
         beep_cnt <= 16'h0000;
         beep_oct <= 2'b00;
         port_f_pin_zero <= 1'b0;
         port_f_pin_zero_alt <= 1'b0;
         port_f_pin_one <= 1'b0;
         port_f_pin_one_alt <= 1'b0;
         spi_ss_level <= 1'b1;
         port_c_pin_seven_free <= 1'b0;
      end
      else
      begin
         osc_half <= ~osc_half;
         cpu_div <= cpu_div + 5'h01;
         if (!misc_control_one[`MCR_SLOW_BIT])
            cpu_clock_enable <= cpu_div[0];
         else
         begin
            case (presc)
               2'b00: cpu_clock_enable <= &cpu_div[1:0];
               2'b10: cpu_clock_enable <= &cpu_div[2:0];
               2'b01: cpu_clock_enable <= &cpu_div[3:0];
               default: cpu_clock_enable <= &cpu_div[4:0];
            endcase
         end
         port_f_pin_zero_alt <= misc_control_one[`MCR_CLK_OUT_BIT];
         // Pin held low in active halt to save power
         port_f_pin_zero <= misc_control_one[`MCR_CLK_OUT_BIT] & ~active_halt
                            & osc_half;
         // Beep ignores active halt; software must turn it off
         port_f_pin_one_alt <= |beep_sel;
         if (beep_sel == 2'b00)
         begin
            beep_cnt <= 16'h0000;
            beep_oct <= 2'b00;
            port_f_pin_one <= 1'b0;
         end
         else if (beep_cnt >= beep_half - 16'h0001)
         begin
            beep_cnt <= 16'h0000;
            beep_oct <= beep_oct + 2'b01;
            case (beep_sel)
               2'b01: port_f_pin_one <= ~port_f_pin_one;
               2'b10: port_f_pin_one <= beep_oct[0] ? ~port_f_pin_one : port_f_pin_one;
               default: port_f_pin_one <= (&beep_oct) ? ~port_f_pin_one : port_f_pin_one;
            endcase
         end
         else
            beep_cnt <= beep_cnt + 16'h0001;
         spi_ss_level <= misc_control_two[`MCR_SS_MODE_BIT] ?
                         misc_control_two[`MCR_SS_INT_BIT] : ss_level;
         port_c_pin_seven_free <= misc_control_two[`MCR_SS_MODE_BIT];
      end
   end
endmodule // mcr_misc_control
`default_nettype wire

/* File: hdl/mcr_map.vh */
/*
 Register offsets, field positions and timing counts for the misc control bank.
 Assumes a 40 MHz system clock standing in for the oscillator clock.
*/
`ifndef MCR_MAP_VH
`define MCR_MAP_VH
`define MCR_OFF_CTRL_ONE 8'h20
`define MCR_OFF_CTRL_TWO 8'h40
`define MCR_OFF_IRQ_STAT 8'h60
`define MCR_OFF_IRQ_MASK 8'h64
`define MCR_RESET_VAL 8'h00
`define MCR_SENS_HI_MSB 7
`define MCR_SENS_HI_LSB 6
`define MCR_CLK_OUT_BIT 5
`define MCR_SENS_LO_MSB 4
`define MCR_SENS_LO_LSB 3
`define MCR_PRESC_MSB 2
`define MCR_PRESC_LSB 1
`define MCR_SLOW_BIT 0
`define MCR_POL_A_BIT 7
`define MCR_POL_B_BIT 6
`define MCR_BEEP_MSB 5
`define MCR_BEEP_LSB 4
`define MCR_TOP_EDGE_BIT 3
`define MCR_TOP_EN_BIT 2
`define MCR_SS_MODE_BIT 1
`define MCR_SS_INT_BIT 0
`define MCR_OSC_HZ 40000000
`define MCR_BEEP_2K_HZ 2000
`define MCR_BEEP_HALF_2K ((`MCR_OSC_HZ / `MCR_BEEP_2K_HZ) / 2)
`endif

/* File: tb/mcr_misc_control_properties.sv */
/*
 Checker for the misc control bank, watching only its top-level ports.
 Assumes one clock and the synchronous active-low reset.
*/
`default_nettype none
module mcr_misc_control_properties (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [31:0] hrdata,
   input wire logic active_halt,
   input wire logic cpu_irq_mask,
   input wire logic spi_ss_pin,
   input wire logic [3:0] ext_irq_req,
   input wire logic cpu_clock_enable,
   input wire logic port_f_pin_zero,
   input wire logic port_f_pin_zero_alt,
   input wire logic port_f_pin_one,
   input wire logic port_f_pin_one_alt,
   input wire logic spi_ss_level,
   input wire logic port_c_pin_seven_free
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic [5:0] gap;
   // Cycles since the last cpu enable pulse
   always @(posedge clock)
      if (!reset_n || cpu_clock_enable)
         gap <= 6'd0;
      else
         gap <= gap + 6'd1;
   AST_RST_CLEAR: assert property ($rose(reset_n) |-> hrdata == 32'h0 &&
      !port_f_pin_zero_alt && !port_f_pin_one_alt && !port_c_pin_seven_free)
      else $error("outputs not clear after reset");
   AST_CPU_PULSE: assert property (cpu_clock_enable |=> !cpu_clock_enable)
      else $error("cpu enable wider than one cycle");
   AST_CPU_GAP: assert property (gap < 6'd32)
      else $error("cpu enable period above 32");
   AST_CLK_TOGGLE: assert property ((port_f_pin_zero_alt && !active_halt)[*3]
      |-> port_f_pin_zero != $past(port_f_pin_zero)) else $error("clock out not toggling");
   AST_CLK_HALT: assert property (active_halt[*3] |-> $stable(port_f_pin_zero))
      else $error("clock out runs in halt");
   AST_BEEP_OFF: assert property ((!port_f_pin_one_alt)[*2] |-> $stable(port_f_pin_one))
      else $error("beep pin moves while off");
   AST_SS_PIN: assert property ((!port_c_pin_seven_free && $stable(spi_ss_pin))[*6]
      |-> spi_ss_level == spi_ss_pin) else $error("slave select not from pin");
   AST_MASKED: assert property (cpu_irq_mask[*2] |-> ext_irq_req == 4'h0)
      else $error("request while cpu masked");
   cover property (cpu_clock_enable ##2 cpu_clock_enable);
   cover property ($rose(port_f_pin_one));
   cover property ($fell(spi_ss_level));
endmodule // mcr_misc_control_properties
`default_nettype wire

/* File: tb/mcr_pin_model.sv */
/*
 Pin-side model: interrupt group levels, top-level pin, slave-select pin.
 Assumes the bench asks for levels; pins move well off the clock edge.
*/
`default_nettype none
module mcr_pin_model (
   input wire logic [3:0] want_grp,
   input wire logic want_top,
   input wire logic want_ss,
   output var logic [3:0] grp_pins,
   output var logic top_pin,
   output var logic ss_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pins are asynchronous to the block clock
   assign #7 grp_pins = want_grp;
   assign #7 top_pin = want_top;
   assign #7 ss_pin = want_ss;
endmodule // mcr_pin_model
`default_nettype wire

/* File: tb/mcr_misc_control_test.sv */
/*
 Self-checking bench for the misc control bank over AHB-Lite.
 Assumes the pin model sits on the far side and the checker is bound below.
*/
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module mcr_misc_control_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic lvl_hi = 1'b0;
   logic lvl_lo = 1'b0;
   logic cpu_irq_mask = 1'b0;
   logic active_halt = 1'b0;
   logic [3:0] cfg_ok = 4'hf;
   logic [3:0] want_grp = 4'hf;
   logic want_top = 1'b0;
   logic want_ss = 1'b1;
   logic [31:0] rd;
   int bad_count = 0;
   int num_checks = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, cpu_clock_enable, port_f_pin_zero, port_f_pin_zero_alt;
   wire port_f_pin_one, port_f_pin_one_alt, spi_ss_level, port_c_pin_seven_free, irq;
   wire [3:0] ext_irq_req, grp_pins;
   wire top_pin, ss_pin, top_irq_req;
   int top_seen = 0;
   always @(posedge clock)
      if (top_irq_req === 1'b1)
         top_seen <= top_seen + 1;
   mcr_misc_control i_mcr_misc_control (.clock(clock), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq_level_bit_high(lvl_hi), .irq_level_bit_low(lvl_lo), .cpu_irq_mask(cpu_irq_mask),
      .active_halt(active_halt), .ext_irq_pins(grp_pins), .ext_irq_config_ok(cfg_ok),
      .top_level_irq_pin(top_pin), .spi_ss_pin(ss_pin), .ext_irq_req(ext_irq_req),
      .top_irq_req(top_irq_req), .cpu_clock_enable(cpu_clock_enable),
      .port_f_pin_zero(port_f_pin_zero),
      .port_f_pin_zero_alt(port_f_pin_zero_alt), .port_f_pin_one(port_f_pin_one),
      .port_f_pin_one_alt(port_f_pin_one_alt), .spi_ss_level(spi_ss_level),
      .port_c_pin_seven_free(port_c_pin_seven_free), .irq(irq));
   mcr_pin_model i_mcr_pin_model (.want_grp(want_grp), .want_top(want_top),
      .want_ss(want_ss), .grp_pins(grp_pins), .top_pin(top_pin), .ss_pin(ss_pin));
   initial
   begin
      forever #12.5 clock = ~clock;
   end
   task automatic give_verdict();
      if (bad_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic rdy();
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 40)
         begin
            bad_count++;
            $display("[ERR] %0t bus timeout", $time);
            give_verdict();
         end
         @(posedge clock);
      end
   endtask
   // Called just after an edge; hsel stays up, idle slots use htrans IDLE
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      rdy();
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      rdy();
      rd = hrdata;
   endtask
   task automatic t_regs();
      xfer(1'b0, 8'h20, 8'h00);
      `CHK(rd, 32'h0)
      `CHK(hresp, 1'b0)
      xfer(1'b0, 8'h40, 8'h00);
      `CHK(rd, 32'h0)
      xfer(1'b1, 8'h20, 8'hff);
      xfer(1'b1, 8'h80, 8'hff);
      xfer(1'b0, 8'h80, 8'h00);
      `CHK(rd, 32'h0)
      xfer(1'b0, 8'h20, 8'h00);
      `CHK(rd, 32'h27)
      xfer(1'b1, 8'h40, 8'h0c);
      xfer(1'b1, 8'h40, 8'h04);
      xfer(1'b0, 8'h40, 8'h00);
      `CHK(rd, 32'h0c)
   endtask
   task automatic t_cpu();
      int n;
      logic [7:0] code [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
      int want [5] = '{32, 16, 8, 4, 2};
      foreach (code[i])
      begin
         xfer(1'b1, 8'h20, code[i]);
         tick(40);
         n = 0;
         repeat (64)
         begin
            @(posedge clock);
            n += int'(cpu_clock_enable === 1'b1);
         end
         `CHK(n, want[i])
      end
   endtask
   task automatic t_clko();
      logic p;
      xfer(1'b1, 8'h20, 8'h20);
      tick(3);
      p = port_f_pin_zero;
      tick(1);
      `CHK(port_f_pin_zero_alt, 1'b1)
      `CHK(port_f_pin_zero, ~p)
      active_halt <= 1'b1;
      tick(4);
      p = port_f_pin_zero;
      tick(1);
      `CHK(port_f_pin_zero, p)
   endtask
   task automatic t_irq();
      lvl_hi <= 1'b1;
      lvl_lo <= 1'b1;
      xfer(1'b1, 8'h20, 8'h50);
      xfer(1'b1, 8'h40, 8'hcc);
      xfer(1'b1, 8'h64, 8'h3e);
      xfer(1'b1, 8'h60, 8'hff);
      xfer(1'b0, 8'h20, 8'h00);
      `CHK(rd, 32'h50)
      want_grp <= 4'h0;
      tick(10);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h0c)
      `CHK(irq, 1'b1)
      xfer(1'b1, 8'h60, 8'h0c);
      want_grp <= 4'hf;
      want_top <= 1'b1;
      tick(10);
      xfer(1'b1, 8'h64, 8'h00);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h32)
      `CHK(irq, 1'b0)
      xfer(1'b1, 8'h60, 8'hff);
      cfg_ok <= 4'h0;
      want_grp <= 4'h0;
      tick(10);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h0)
      cfg_ok <= 4'hf;
      xfer(1'b1, 8'h20, 8'hc0);
      xfer(1'b1, 8'h40, 8'hc8);
      tick(2);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h24)
      `CHK(top_seen, 2)
      xfer(1'b1, 8'h60, 8'hff);
      want_grp <= 4'hf;
      tick(10);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h1e)
      xfer(1'b1, 8'h60, 8'hff);
      tick(2);
      xfer(1'b0, 8'h60, 8'h00);
      `CHK(rd, 32'h02)
      `CHK(ext_irq_req, 4'h1)
   endtask
   task automatic t_ss();
      cpu_irq_mask <= 1'b1;
      want_ss <= 1'b0;
      xfer(1'b1, 8'h40, 8'h03);
      tick(6);
      `CHK(spi_ss_level, 1'b1)
      `CHK(port_c_pin_seven_free, 1'b1)
      xfer(1'b1, 8'h40, 8'h00);
      tick(6);
      `CHK(spi_ss_level, 1'b0)
      want_ss <= 1'b1;
      tick(6);
      `CHK(spi_ss_level, 1'b1)
   endtask
   // Cycles between two beep pin changes, bounded
   task automatic beep_half(output int h);
      logic p;
      repeat (2)
      begin
         h = 0;
         p = port_f_pin_one;
         while (port_f_pin_one === p && h < 50000)
         begin
            @(posedge clock);
            h++;
         end
      end
   endtask
   task automatic t_beep();
      int h;
      xfer(1'b1, 8'h40, 8'h10);
      tick(2);
      `CHK(port_f_pin_one_alt, 1'b1)
      beep_half(h);
      `CHK(h, 10000)
      xfer(1'b1, 8'h40, 8'h20);
      beep_half(h);
      `CHK(h, 20000)
      xfer(1'b1, 8'h40, 8'h30);
      tick(2);
      `CHK(port_f_pin_one_alt, 1'b1)
      xfer(1'b1, 8'h40, 8'h00);
      tick(2);
      `CHK(port_f_pin_one_alt, 1'b0)
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_cpu();
      t_clko();
      t_irq();
      t_ss();
      t_beep();
      give_verdict();
   end
endmodule // mcr_misc_control_test
bind mcr_misc_control mcr_misc_control_properties i_mcr_misc_control_properties (
   .clock(clock), .reset_n(reset_n), .hrdata(hrdata), .active_halt(active_halt),
   .cpu_irq_mask(cpu_irq_mask), .spi_ss_pin(spi_ss_pin), .ext_irq_req(ext_irq_req),
   .cpu_clock_enable(cpu_clock_enable), .port_f_pin_zero(port_f_pin_zero),
   .port_f_pin_zero_alt(port_f_pin_zero_alt), .port_f_pin_one(port_f_pin_one),
   .port_f_pin_one_alt(port_f_pin_one_alt), .spi_ss_level(spi_ss_level),
   .port_c_pin_seven_free(port_c_pin_seven_free));
`default_nettype wire
